// ==== src/ssp_sram_port.sv ====
// Control, burst addressing and data-pin steering of a flow-through burst SRAM
// Functional notes
// - Address inputs are captured on a qualified rising edge and select one location.
// - The two low address bits load a two-bit burst counter.
// - Active-low lane strobes enable their byte lane only in a write sequence: at the load with write strobe low, and at each advance.
// - Write strobe low at a qualified edge starts a write sequence.
// - Advance high at a qualified edge steps the burst counter instead.
// - Advance low at a qualified edge loads a new start address.
// - Edges act only while the clock gate is low.
// - Raising the clock gate stretches the cycle without deselecting.
// - Three chip selects: first and third active low, second active high.
// - Output enable low drives data lines; high floats them as inputs.
// - Data lines stay undriven in write data phase, after deselect, and deselected.
// - Sleep high parks the device quietly with contents preserved.
// - Sleep must be low or open for normal operation; open reads low. sleep_request has no pull-down here; the bench model drives it low.
// - Read data belongs to the address captured at the previous edge.
// - Order strap low gives linear bursts; high or open gives interleaved. burst_order has no pull-up here; only a driven high gives interleaved.
// - Clock gate high retains counter, phase and all pipeline state.
`timescale 1ns/1ns
`default_nettype none
module ssp_sram_port #(
  parameter int AW     = 10,
  parameter int DATA_W = 32
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [3:0]        lane_write_n,
  input  wire logic              write_n,
  input  wire logic              advance_or_load,
  input  wire logic              select1_n,
  input  wire logic              select2,
  input  wire logic              select3_n,
  input  wire logic              clock_gate_n,
  input  wire logic              output_enable_n,
  input  wire logic              sleep_request,
  input  wire logic              burst_order,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  input  wire logic [3:0]        parity_lines_in,
  output logic      [3:0]        parity_lines_out,
  output logic                   parity_lines_oe
);
  localparam int DW = DATA_W + ssp_pkg::LANES;

  ssp_mem_if #(.AW(AW), .DW(DW)) mem ();

  ssp_pkg::ssp_phase_t phase_q, phase_d;
  logic [AW-1:2]       base_q, base_d;
  logic [1:0]          start_q, start_d;
  logic [1:0]          seq_q, seq_d;
  logic [3:0]          mask_q, mask_d;

  wire qual      = ~clock_gate_n & ~sleep_request;
  wire selected  = ~select1_n & select2 & ~select3_n;
  wire do_load   = qual & ~advance_or_load & selected;
  wire do_desel  = qual & ~advance_or_load & ~selected;
  wire do_adv    = qual & advance_or_load & (phase_q != ssp_pkg::PH_IDLE);
  wire [1:0] seq_next  = 2'(seq_q + ssp_pkg::SEQ_STEP);
  wire [3:0] lanes_on  = ~lane_write_n;
  wire [1:0] cur_off   = ssp_pkg::burst_offset(start_q, seq_q, burst_order);
  wire [1:0] next_off  = ssp_pkg::burst_offset(start_q, seq_next, burst_order);
  wire [AW-1:0] cur_addr  = {base_q, cur_off};
  wire [AW-1:0] adv_addr  = {base_q, next_off};

  // Next state; an advance keeps the kind of access that the load chose
  always_comb begin
    phase_d = phase_q;
    base_d  = base_q;
    start_d = start_q;
    seq_d   = seq_q;
    mask_d  = mask_q;
    if (do_load) begin
      base_d  = addr[AW-1:2];
      start_d = addr[1:0];
      seq_d   = ssp_pkg::SEQ_START;
      phase_d = write_n ? ssp_pkg::PH_READ : ssp_pkg::PH_WRITE;
      mask_d  = write_n ? ssp_pkg::MASK_NONE : lanes_on;
    end else if (do_desel) begin
      phase_d = ssp_pkg::PH_IDLE;
      mask_d  = ssp_pkg::MASK_NONE;
    end else if (do_adv) begin
      seq_d   = seq_next;
      mask_d  = (phase_q == ssp_pkg::PH_WRITE) ? lanes_on : ssp_pkg::MASK_NONE;
    end
  end

  // Sleep counts as a gated edge here: it is sampled, not an asynchronous stop
  // Gated edges fall through with every _d equal to its _q
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_q <= ssp_pkg::PH_IDLE;
      base_q  <= '0;
      start_q <= ssp_pkg::SEQ_START;
      seq_q   <= ssp_pkg::SEQ_START;
      mask_q  <= ssp_pkg::MASK_NONE;
    end else begin
      phase_q <= phase_d;
      base_q  <= base_d;
      start_q <= start_d;
      seq_q   <= seq_d;
      mask_q  <= mask_d;
    end
  end

  // Late write: data arrives in the cycle after its address edge
  wire write_phase = (phase_q == ssp_pkg::PH_WRITE);
  wire read_phase  = (phase_q == ssp_pkg::PH_READ);
  logic [DW-1:0] pin_word;
  always_comb begin
    pin_word = '0;
    for (int k = 0; k < ssp_pkg::LANES; k++) begin
      pin_word[k*ssp_pkg::LANE_BITS +: ssp_pkg::LANE_BITS] =
        {parity_lines_in[k], data_in[k*ssp_pkg::BYTE_BITS +: ssp_pkg::BYTE_BITS]};
    end
  end

  assign mem.wr_en   = qual & write_phase & (|mask_q);
  assign mem.wr_addr = cur_addr;
  assign mem.wr_data = pin_word;
  assign mem.wr_mask = mask_q;
  assign mem.rd_en   = rst_b & qual & (phase_d == ssp_pkg::PH_READ);
  assign mem.rd_addr = do_load ? addr : adv_addr;

  // The store resolves a write and a read of one word at one edge to the new data
  ssp_word_store #(.AW(AW), .DW(DW)) u_store (
    .ref_clk (ref_clk),
    .mem     (mem)
  );

  // Read data register lives in the store, so the pins see flopped data
  always_comb begin
    data_out         = '0;
    parity_lines_out = '0;
    for (int k = 0; k < ssp_pkg::LANES; k++) begin
      data_out[k*ssp_pkg::BYTE_BITS +: ssp_pkg::BYTE_BITS] =
        mem.rd_data[k*ssp_pkg::LANE_BITS +: ssp_pkg::BYTE_BITS];
      parity_lines_out[k] = mem.rd_data[k*ssp_pkg::LANE_BITS + ssp_pkg::BYTE_BITS];
    end
  end

  // Only a read data phase may drive; write, idle and sleep always float
  assign data_oe         = ~output_enable_n & read_phase & ~sleep_request;
  assign parity_lines_oe = data_oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Sequencing: loads, advances and deselects
  AST_RESET_IDLE: assert property ($rose(rst_b) |-> phase_q == ssp_pkg::PH_IDLE && !data_oe && !mem.wr_en)
    else $error("device not idle after reset");
  AST_LOAD_ADDR: assert property (do_load |=> base_q == $past(addr[AW-1:2]) && start_q == $past(addr[1:0])
    && seq_q == ssp_pkg::SEQ_START)
    else $error("load did not capture address");
  AST_ADVANCE: assert property (do_adv |=> seq_q == 2'($past(seq_q) + 2'h1)
    && $stable(base_q) && $stable(start_q))
    else $error("advance did not step within group");
  AST_DESELECT: assert property (do_desel |=> phase_q == ssp_pkg::PH_IDLE)
    else $error("bad select combination did not deselect");
  AST_IDLE_NO_ADV: assert property ((phase_q == ssp_pkg::PH_IDLE && advance_or_load)
    |=> phase_q == ssp_pkg::PH_IDLE)
    else $error("advance left deselect");
  AST_BURST_UPPER: assert property ((do_adv && read_phase)
    |-> mem.rd_en && mem.rd_addr[AW-1:2] == base_q)
    else $error("burst left its group of four");
  AST_ORDER_LIN: assert property ((do_adv && read_phase && !burst_order)
    |-> mem.rd_addr[1:0] == 2'(start_q + seq_q + 2'h1))
    else $error("linear burst step wrong");
  AST_ORDER_ILV: assert property ((do_adv && read_phase && burst_order)
    |-> mem.rd_addr[1:0] == (start_q ^ 2'(seq_q + 2'h1)))
    else $error("interleaved burst step wrong");

  // Clock gate and sleep hold everything, the read register included
  AST_GATE_HOLD: assert property (clock_gate_n |=> $stable(phase_q) && $stable(seq_q) && $stable(base_q)
    && $stable(start_q) && $stable(mask_q))
    else $error("state changed while clock gate high");
  AST_GATE_NO_DESEL: assert property ((clock_gate_n && phase_q != ssp_pkg::PH_IDLE)
    |=> phase_q != ssp_pkg::PH_IDLE)
    else $error("clock gate deselected device");
  AST_GATE_NO_MEM: assert property ((clock_gate_n || sleep_request) |-> !mem.wr_en && !mem.rd_en)
    else $error("store accessed on an ignored edge");
  AST_GATE_DATA: assert property ((clock_gate_n || sleep_request) |=> $stable(mem.rd_data))
    else $error("read register changed on an ignored edge");
  AST_SLEEP: assert property (sleep_request |-> !mem.wr_en && !data_oe ##1 $stable(phase_q))
    else $error("activity during sleep");

  // Write lanes and the kind of access
  AST_WRITE_LANES: assert property ((do_load && !write_n) |=> write_phase && mask_q == ~$past(lane_write_n))
    else $error("write lanes not captured");
  AST_WRITE_ADV_MASK: assert property ((do_adv && write_phase) |=> mask_q == ~$past(lane_write_n))
    else $error("write lanes not captured on advance");
  AST_READ_NO_MASK: assert property ((do_load && write_n) |=> read_phase && mask_q == ssp_pkg::MASK_NONE)
    else $error("read carried write lanes");
  AST_WRITE_NO_READ: assert property ((write_phase && !(do_load && write_n)) |-> !mem.rd_en)
    else $error("read issued inside a write sequence");
  AST_IDLE_NO_WRITE: assert property ((phase_q == ssp_pkg::PH_IDLE) |-> !mem.wr_en)
    else $error("write while deselected");
  AST_READ_ISSUE: assert property ((do_load && write_n) |-> mem.rd_en && mem.rd_addr == addr)
    else $error("read not issued at address edge");

  // Pin steering; a read data phase is the only time the pins drive
  AST_OE_FLOAT: assert property (!read_phase |-> !data_oe && !parity_lines_oe)
    else $error("pins driven outside read phase");
  AST_OE_PIN: assert property ((read_phase && !sleep_request) |-> data_oe == !output_enable_n)
    else $error("output enable not followed");
  AST_DESEL_FLOAT: assert property (do_desel |=> !data_oe && !parity_lines_oe)
    else $error("pins driven after deselect");
  AST_WRITE_FLOAT: assert property ((do_load && !write_n) |=> !data_oe && !parity_lines_oe)
    else $error("pins driven in write data phase");

  // Main scenarios the bench is expected to reach
  COV_READ_LOAD:  cover property (do_load && write_n ##1 read_phase && data_oe);
  COV_WRITE_LOAD: cover property (do_load && !write_n ##1 mem.wr_en);
  COV_BURST:      cover property (do_adv ##1 do_adv ##1 do_adv);
  COV_GATED:      cover property (read_phase && clock_gate_n ##1 read_phase);
  COV_SLEEP_WAKE: cover property (sleep_request && read_phase ##1 !sleep_request && data_oe);
endmodule : ssp_sram_port
`default_nettype wire

// ==== shared/ssp_pkg.sv ====
// Shared constants, types and burst-order arithmetic for the burst SRAM port
`default_nettype none
package ssp_pkg;
  localparam int          LANES      = 4;
  localparam int          BYTE_BITS  = 8;
  localparam int          LANE_BITS  = 9;
  localparam int          BURST_W    = 2;
  localparam logic [1:0]  SEQ_START  = 2'h0;
  localparam logic [1:0]  SEQ_STEP   = 2'h1;
  localparam logic [3:0]  MASK_NONE  = 4'h0;
  localparam logic        ORDER_LINEAR = 1'b0;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_READ  = 2'b01,
    PH_WRITE = 2'b10
  } ssp_phase_t;

  // Offset inside the group of four: linear adds, interleaved toggles bits
  function automatic logic [1:0] burst_offset(input logic [1:0] start,
                                              input logic [1:0] seq,
                                              input logic       order);
    burst_offset = (order == ORDER_LINEAR) ? 2'(start + seq) : (start ^ seq);
  endfunction : burst_offset
endpackage : ssp_pkg
`default_nettype wire

// ==== shared/ssp_mem_if.sv ====
// Carrier between the port control and the word store
`timescale 1ns/1ns
`default_nettype none
interface ssp_mem_if #(parameter int AW = 10, parameter int DW = 36);
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [3:0]    wr_mask;

  modport ctrl  (output rd_en, rd_addr, wr_en, wr_addr, wr_data, wr_mask, input rd_data);
  modport store (input rd_en, rd_addr, wr_en, wr_addr, wr_data, wr_mask, output rd_data);
endinterface : ssp_mem_if
`default_nettype wire

// ==== src/ssp_word_store.sv ====
// Lane-masked word store with registered read data
`timescale 1ns/1ns
`default_nettype none
module ssp_word_store #(
  parameter int AW = 10,
  parameter int DW = 36
) (
  input  wire logic ref_clk,
  ssp_mem_if.store  mem
);
  logic [DW-1:0] words [0:(1<<AW)-1];
  logic [DW-1:0] merged;
  logic [DW-1:0] rd_q;

  // Lanes without their mask bit keep the stored value
  always_comb begin
    merged = words[mem.wr_addr];
    for (int k = 0; k < ssp_pkg::LANES; k++) begin
      if (mem.wr_mask[k]) begin
        merged[k*ssp_pkg::LANE_BITS +: ssp_pkg::LANE_BITS] = mem.wr_data[k*ssp_pkg::LANE_BITS +: ssp_pkg::LANE_BITS];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem.wr_en) begin
      words[mem.wr_addr] <= merged;
    end
  end

  // Write-first on a collision so a read right after a write sees new data
  always_ff @(posedge ref_clk) begin
    if (mem.rd_en) begin
      rd_q <= (mem.wr_en && mem.wr_addr == mem.rd_addr) ? merged : words[mem.rd_addr];
    end
  end

  assign mem.rd_data = rd_q;
endmodule : ssp_word_store
`default_nettype wire

// ==== test/ssp_ctrl_model.sv ====
// Controller-side model of the shared data wire and the sleep line
`timescale 1ns/1ns
`default_nettype none
module ssp_ctrl_model (
  input  wire logic        ref_clk,
  input  wire logic        ctl_oe,
  input  wire logic [35:0] ctl_data,
  input  wire logic        dev_oe,
  input  wire logic [35:0] dev_data,
  input  wire logic        slp_en,
  output logic      [35:0] bus,
  output logic             sleep_line
);
  logic [35:0] last_q = 36'h0;
  // A released wire toggles every cycle so a stale value never passes as data
  always @(posedge ref_clk) last_q <= bus;
  assign bus = dev_oe ? dev_data : (ctl_oe ? ctl_data : ~last_q);
  // Driven low whenever slp_en is low; the sleep line is never left undriven
  assign sleep_line = slp_en ? 1'b1 : 1'b0;
endmodule : ssp_ctrl_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [2:0] OK  = 3'h2;
  localparam logic [2:0] DES = 3'h7;
  logic             ref_clk = 1'b0;
  logic             rst_b   = 1'b0;
  logic             write_n = 1'b1;
  logic             adv     = 1'b0;
  logic             gate_n  = 1'b0;
  logic             oe_n    = 1'b0;
  logic             order   = 1'b0;
  logic             ctl_oe  = 1'b0;
  logic             slp_en  = 1'b0;
  logic [9:0]       addr    = 10'h0;
  logic [3:0]       lanes_n = 4'hF;
  logic [2:0]       sel     = 3'h7;
  logic [35:0]      ctl_data = 36'h0;
  wire logic [35:0] bus;
  wire logic [31:0] data_out;
  wire logic [3:0]  par_out;
  wire logic        data_oe;
  wire logic        par_oe;
  wire logic        sleep_line;
  logic [35:0]      mdl [int];
  int               errors = 0;
  int               checks_done = 0;
  int               seed = 92;

  initial forever #4 ref_clk = ~ref_clk;

  ssp_sram_port #(.AW(10), .DATA_W(32)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
    .lane_write_n(lanes_n), .write_n(write_n), .advance_or_load(adv), .select1_n(sel[2]),
    .select2(sel[1]), .select3_n(sel[0]), .clock_gate_n(gate_n), .output_enable_n(oe_n),
    .sleep_request(sleep_line), .burst_order(order), .data_in(bus[31:0]), .data_out(data_out),
    .data_oe(data_oe), .parity_lines_in(bus[35:32]), .parity_lines_out(par_out), .parity_lines_oe(par_oe));

  ssp_ctrl_model partner (.ref_clk(ref_clk), .ctl_oe(ctl_oe), .ctl_data(ctl_data), .dev_oe(data_oe),
    .dev_data({par_out, data_out}), .slp_en(slp_en), .bus(bus), .sleep_line(sleep_line));

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic step(input logic a_ld, input logic wr, input logic [9:0] a, input logic [3:0] ln,
                      input logic [2:0] s, input logic g, input logic drv, input logic [35:0] wd);
    @(posedge ref_clk);
    adv <= a_ld;
    write_n <= wr;
    addr <= a;
    lanes_n <= ln;
    sel <= s;
    gate_n <= g;
    ctl_oe <= drv;
    ctl_data <= wd;
  endtask : step

  task automatic look(input logic eoe, input logic [35:0] exp, input logic cd);
    #2;
    chk({34'h0, data_oe, par_oe}, {34'h0, eoe, eoe});
    if (cd) chk({par_out, data_out}, exp);
  endtask : look

  function automatic logic [9:0] baddr(input logic [9:0] s, input int i);
    baddr = order ? {s[9:2], s[1:0] ^ 2'(i)} : {s[9:2], 2'(s[1:0] + 2'(i))};
  endfunction : baddr

  task automatic wburst(input logic [9:0] s, input logic [3:0] ln, input int n);
    logic [35:0] wd;
    logic [35:0] msk;
    logic [9:0]  a;
    step(1'b0, 1'b0, s, ln, OK, 1'b0, 1'b0, 36'h0);
    for (int i = 0; i < n; i++) begin
      wd = 36'({$random(seed), $random(seed)});
      a = baddr(s, i);
      msk = 36'h0;
      for (int k = 0; k < 4; k++) if (!ln[k]) msk = msk | (36'h0FF << (8 * k)) | (36'h1 << (32 + k));
      if (!mdl.exists(a)) mdl[a] = 36'h0;
      mdl[a] = (mdl[a] & ~msk) | (wd & msk);
      step(i < n - 1, 1'b0, s, ln, (i < n - 1) ? OK : DES, 1'b0, 1'b1, wd);
      look(1'b0, 36'h0, 1'b0);
    end
  endtask : wburst

  task automatic rburst(input logic [9:0] s, input int n);
    step(1'b0, 1'b1, s, 4'hF, OK, 1'b0, 1'b0, 36'h0);
    for (int i = 0; i < n; i++) begin
      step(i < n - 1, 1'b1, s, 4'hF, (i < n - 1) ? OK : DES, 1'b0, 1'b0, 36'h0);
      look(!oe_n, mdl[baddr(s, i)], 1'b1);
    end
  endtask : rburst

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    wburst(10'h041, 4'h0, 4);
    rburst(10'h042, 4);
    order <= 1'b1;
    rburst(10'h043, 4);
    for (int m = 1; m < 4; m++) begin
      wburst(10'h041, 4'(m * 5), 1);
      rburst(10'h041, 1);
    end
    for (int c = 0; c < 8; c++) if (c != 2) begin
      step(1'b0, 1'b1, 10'h040, 4'hF, 3'(c), 1'b0, 1'b0, 36'h0);
      step(1'b1, 1'b1, 10'h040, 4'hF, OK, 1'b0, 1'b0, 36'h0);
      look(1'b0, 36'h0, 1'b0);
      step(1'b0, 1'b1, 10'h040, 4'hF, DES, 1'b0, 1'b0, 36'h0);
      look(1'b0, 36'h0, 1'b0);
    end
    // Gated edges carry a write-with-deselect that must be ignored
    step(1'b0, 1'b1, 10'h040, 4'hF, OK, 1'b0, 1'b0, 36'h0);
    repeat (3) begin
      step(1'b0, 1'b0, 10'h3FF, 4'h0, DES, 1'b1, 1'b1, 36'h0);
      look(1'b1, mdl[10'h040], 1'b1);
    end
    step(1'b1, 1'b1, 10'h3FF, 4'hF, OK, 1'b0, 1'b0, 36'h0);
    look(1'b1, mdl[10'h040], 1'b1);
    step(1'b0, 1'b1, 10'h040, 4'hF, DES, 1'b0, 1'b0, 36'h0);
    look(1'b1, mdl[10'h041], 1'b1);
    oe_n <= 1'b1;
    rburst(10'h042, 1);
    oe_n <= 1'b0;
    step(1'b0, 1'b1, 10'h042, 4'hF, OK, 1'b0, 1'b0, 36'h0);
    step(1'b0, 1'b0, 10'h042, 4'h0, DES, 1'b0, 1'b0, 36'h0);
    look(1'b1, mdl[10'h042], 1'b1);
    slp_en <= 1'b1;
    look(1'b0, mdl[10'h042], 1'b1);
    repeat (2) step(1'b0, 1'b0, 10'h042, 4'h0, DES, 1'b0, 1'b1, 36'h0);
    look(1'b0, mdl[10'h042], 1'b1);
    slp_en <= 1'b0;
    look(1'b1, mdl[10'h042], 1'b1);
    rburst(10'h042, 1);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
